//--- ctn_params.svh
// Purpose: Offsets, field positions, reset values for thermal/thermistor config regs
// Assumes: 8-bit register port with 8-bit offsets
// Notes:   Definitions only
`ifndef CTN_PARAMS_SVH
`define CTN_PARAMS_SVH

`define CTN_OFS_CTRL5      8'h14
`define CTN_OFS_RSVD       8'h15
`define CTN_OFS_TEMP       8'h16
`define CTN_OFS_NTC0       8'h17
`define CTN_OFS_NTC1       8'h18

`define CTN_RST_RSVD       8'h00
`define CTN_RST_TEMP       8'hC0
`define CTN_RST_NTC0       8'h7A
`define CTN_RST_NTC1       8'h54

`define CTN_BIT_OC_EN      0
`define CTN_BIT_SHIP       7

// Writable masks; reserved bits stay zero
`define CTN_MASK_TEMP      8'hFE
`define CTN_MASK_NTC0      8'hFE
`define CTN_MASK_NTC1      8'hFF
// Bits of the temperature register kept across watchdog expiry
`define CTN_KEEP_TEMP      8'h0E

`define CTN_NTC1_IGNORE    0
`define CTN_TS_NORMAL      4'h0

`endif

//--- ctn_pkg.sv
// Purpose: Types for the thermal/thermistor config register block
// Assumes: Used together with ctn_params.svh
// Notes:   Packed field layouts of the temperature, NTC0 and NTC1 registers
package ctn_pkg;

  typedef struct packed {
    logic [1:0] thermal_regulation_select;
    logic [1:0] thermal_shutdown_select;
    logic       bus_input_pulldown_enable;
    logic       aux_input_one_pulldown_enable;
    logic       aux_input_two_pulldown_enable;
    logic       rsvd;
  } ctn_temp_s;

  typedef struct packed {
    logic [2:0] warm_zone_voltage_select;
    logic [1:0] warm_zone_current_select;
    logic [1:0] cool_zone_current_select;
    logic       rsvd;
  } ctn_ntc0_s;

  typedef struct packed {
    logic [1:0] cool_boundary_threshold;
    logic [1:0] warm_boundary_threshold;
    logic [1:0] otg_hot_limit;
    logic       otg_cold_limit;
    logic       thermistor_override;
  } ctn_ntc1_s;

endpackage : ctn_pkg

//--- ctn_regs.sv
// Purpose: Thermal limit and thermistor configuration registers of a charger
// Assumes: Host control port delivers single-cycle write/read strobes in this clock
// Notes:   Register-reset and watchdog-expiry are one-cycle pulses from same domain
`timescale 1ns/1ns
`include "ctn_params.svh"

module ctn_regs
  import ctn_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_reg_reset,
  input  wire logic       i_wdog_expire,
  input  wire logic [3:0] i_ts_status_raw,
  output logic      [7:0] o_rdata,
  output logic            o_discharge_overcurrent_enable,
  output logic            o_ship_switch_fitted,
  output ctn_temp_s       o_temp_cfg,
  output ctn_ntc0_s       o_ntc0_cfg,
  output ctn_ntc1_s       o_ntc1_cfg,
  output logic      [3:0] o_ts_status,
  output logic            o_ts_good_forced
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic       ship;
  logic       oc_en;
  logic [7:0] temp_q;
  logic [7:0] ntc0_q;
  logic [7:0] ntc1_q;
  logic [7:0] rdata;
  logic [3:0] ts_stat;
  logic       ts_forced;

  logic       next_ship;
  logic       next_oc_en;
  logic [7:0] next_temp_q;
  logic [7:0] next_ntc0_q;
  logic [7:0] next_ntc1_q;
  logic [7:0] next_rdata;
  logic [3:0] next_ts_stat;
  logic       next_ts_forced;

  logic       wr5;
  logic       wr16;
  logic       wr17;
  logic       wr18;

  assign wr5  = i_wr_en && (i_addr == `CTN_OFS_CTRL5);
  assign wr16 = i_wr_en && (i_addr == `CTN_OFS_TEMP);
  assign wr17 = i_wr_en && (i_addr == `CTN_OFS_NTC0);
  assign wr18 = i_wr_en && (i_addr == `CTN_OFS_NTC1);

  // ------------------------------------------------------------
  // Next-state of the register bank
  // ------------------------------------------------------------
  always_comb begin
    next_ship   = ship;
    next_oc_en  = oc_en;
    next_temp_q = temp_q;
    next_ntc0_q = ntc0_q;
    next_ntc1_q = ntc1_q;
    if (i_reg_reset) begin
      // Ship-present bit has no reset source besides power-on
      next_oc_en  = 1'b0;
      next_temp_q = `CTN_RST_TEMP;
      next_ntc0_q = `CTN_RST_NTC0;
      next_ntc1_q = `CTN_RST_NTC1;
    end else if (i_wdog_expire) begin
      next_oc_en  = 1'b0;
      // Pull-down enables survive the watchdog
      next_temp_q = (temp_q & `CTN_KEEP_TEMP)
                  | (`CTN_RST_TEMP & ~`CTN_KEEP_TEMP);
      next_ntc0_q = `CTN_RST_NTC0;
      next_ntc1_q = `CTN_RST_NTC1;
    end else begin
      if (wr5) begin
        next_ship  = i_wdata[`CTN_BIT_SHIP];
        next_oc_en = i_wdata[`CTN_BIT_OC_EN];
      end
      if (wr16) begin
        next_temp_q = i_wdata & `CTN_MASK_TEMP;
      end
      if (wr17) begin
        next_ntc0_q = i_wdata & `CTN_MASK_NTC0;
      end
      if (wr18) begin
        next_ntc1_q = i_wdata & `CTN_MASK_NTC1;
      end
    end
    // Without a ship switch the enable is locked low
    if (!next_ship) begin
      next_oc_en = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read data and thermistor status
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = rdata;
    if (i_rd_en) begin
      case (i_addr)
        `CTN_OFS_CTRL5: next_rdata = {ship, 6'h00, oc_en};
        `CTN_OFS_RSVD:  next_rdata = `CTN_RST_RSVD;
        `CTN_OFS_TEMP:  next_rdata = temp_q;
        `CTN_OFS_NTC0:  next_rdata = ntc0_q;
        `CTN_OFS_NTC1:  next_rdata = ntc1_q;
        default:        next_rdata = 8'h00;
      endcase
    end
    next_ts_forced = ntc1_q[`CTN_NTC1_IGNORE];
    // Override reports a normal zone regardless of the comparators
    next_ts_stat   = ntc1_q[`CTN_NTC1_IGNORE] ? `CTN_TS_NORMAL
                                              : i_ts_status_raw;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ship      <= 1'b0;
      oc_en     <= 1'b0;
      temp_q    <= `CTN_RST_TEMP;
      ntc0_q    <= `CTN_RST_NTC0;
      ntc1_q    <= `CTN_RST_NTC1;
      rdata     <= 8'h00;
      ts_stat   <= 4'h0;
      ts_forced <= 1'b0;
    end else begin
      ship      <= next_ship;
      oc_en     <= next_oc_en;
      temp_q    <= next_temp_q;
      ntc0_q    <= next_ntc0_q;
      ntc1_q    <= next_ntc1_q;
      rdata     <= next_rdata;
      ts_stat   <= next_ts_stat;
      ts_forced <= next_ts_forced;
    end
  end

  assign o_rdata                        = rdata;
  assign o_discharge_overcurrent_enable = oc_en;
  assign o_ship_switch_fitted           = ship;
  assign o_temp_cfg                     = ctn_temp_s'(temp_q);
  assign o_ntc0_cfg                     = ctn_ntc0_s'(ntc0_q);
  assign o_ntc1_cfg                     = ctn_ntc1_s'(ntc1_q);
  assign o_ts_status                    = ts_stat;
  assign o_ts_good_forced               = ts_forced;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_regrst;
    i_reg_reset;
  endsequence

  sequence s_wdog_only;
    i_wdog_expire && !i_reg_reset;
  endsequence

  sequence s_wr_ctrl5;
    wr5 && !i_reg_reset && !i_wdog_expire;
  endsequence

  sequence s_wr_temp;
    wr16 && !i_reg_reset && !i_wdog_expire;
  endsequence

  sequence s_wr_ntc0;
    wr17 && !i_reg_reset && !i_wdog_expire;
  endsequence

  sequence s_rd_ctrl5;
    i_rd_en && i_addr == `CTN_OFS_CTRL5;
  endsequence

  sequence s_rd_temp;
    i_rd_en && i_addr == `CTN_OFS_TEMP;
  endsequence

  sequence s_rd_ntc0;
    i_rd_en && i_addr == `CTN_OFS_NTC0;
  endsequence

  sequence s_rd_ntc1;
    i_rd_en && i_addr == `CTN_OFS_NTC1;
  endsequence

  chk_oc_lock_low: assert property (!ship |-> !oc_en)
    else $error("overcurrent enable set without ship switch");
  chk_oc_wdog_clear: assert property (s_wdog_only |=> !oc_en)
    else $error("overcurrent enable survived watchdog");
  chk_rsvd_read: assert property (i_rd_en && i_addr == `CTN_OFS_RSVD |=> rdata == 8'h00)
    else $error("reserved register read nonzero");
  chk_temp_regrst: assert property (s_regrst |=> temp_q == 8'hC0)
    else $error("temperature register reset value wrong");
  chk_ntc0_regrst: assert property (s_regrst |=> ntc0_q == 8'h7A)
    else $error("zone derating reset value wrong");
  chk_ntc1_regrst: assert property (s_regrst |=> ntc1_q == 8'h54)
    else $error("threshold select reset value wrong");
  chk_pd_keep_wdog: assert property (s_wdog_only |=> temp_q[3:1] == $past(temp_q[3:1]))
    else $error("pull-down enables changed on watchdog");
  chk_treg_wdog: assert property (s_wdog_only |=> temp_q[7:4] == 4'hC)
    else $error("thermal selects not restored on watchdog");
  chk_rsvd_bits: assert property (temp_q[0] == 1'b0 && ntc0_q[0] == 1'b0)
    else $error("reserved bit became set");
  chk_ts_override: assert property (ntc1_q[0] |=> ts_stat == 4'h0 && ts_forced)
    else $error("thermistor status not forced normal");
  chk_ntc1_write: assert property (wr18 && !i_reg_reset && !i_wdog_expire
                                   |=> ntc1_q == $past(i_wdata))
    else $error("threshold select write lost");

  // Control 5: ship bit and overcurrent enable
  chk_oc_regrst: assert property (s_regrst |=> !oc_en)
    else $error("overcurrent enable survived register reset");
  chk_oc_write: assert property (s_wr_ctrl5 |=>
                                 oc_en == ($past(i_wdata[0]) && $past(i_wdata[7])))
    else $error("overcurrent enable write handled wrongly");
  chk_ship_write: assert property (s_wr_ctrl5 |=> ship == $past(i_wdata[7]))
    else $error("ship switch bit write lost");
  chk_ship_keep: assert property (i_reg_reset || i_wdog_expire |=> ship == $past(ship))
    else $error("ship switch bit changed by reset command");
  chk_ctrl5_read: assert property (s_rd_ctrl5 |=>
                                   rdata == {$past(ship), 6'h00, $past(oc_en)})
    else $error("control 5 read wrong");

  // Thermal limits register
  chk_temp_write: assert property (s_wr_temp |=>
                                   temp_q == ($past(i_wdata) & `CTN_MASK_TEMP))
    else $error("temperature register write lost");
  chk_tshut_wdog: assert property (s_wdog_only |=> temp_q[5:4] == 2'h0)
    else $error("shutdown select not restored on watchdog");
  chk_bus_pd_regrst: assert property (s_regrst |=> !temp_q[3])
    else $error("bus pull-down survived register reset");
  chk_aux_pd_regrst: assert property (s_regrst |=> temp_q[2:1] == 2'h0)
    else $error("aux pull-downs survived register reset");
  chk_aux_pd_wdog: assert property (s_wdog_only |=> temp_q[2:1] == $past(temp_q[2:1]))
    else $error("aux pull-downs changed on watchdog");
  chk_temp_read: assert property (s_rd_temp |=> rdata == $past(temp_q))
    else $error("temperature register read wrong");

  // Zone derating register
  chk_ntc0_write: assert property (s_wr_ntc0 |=>
                                   ntc0_q == ($past(i_wdata) & `CTN_MASK_NTC0))
    else $error("zone derating write lost");
  chk_vset_wdog: assert property (s_wdog_only |=> ntc0_q[7:5] == 3'h3)
    else $error("warm voltage select not restored on watchdog");
  chk_iseth_wdog: assert property (s_wdog_only |=> ntc0_q[4:3] == 2'h3)
    else $error("warm current select not restored on watchdog");
  chk_isetc_wdog: assert property (s_wdog_only |=> ntc0_q[2:1] == 2'h1)
    else $error("cool current select not restored on watchdog");
  chk_ntc0_read: assert property (s_rd_ntc0 |=> rdata == $past(ntc0_q))
    else $error("zone derating read wrong");

  // Threshold select register
  chk_cool_thr_wdog: assert property (s_wdog_only |=> ntc1_q[7:6] == 2'h1)
    else $error("cool threshold not restored on watchdog");
  chk_warm_thr_wdog: assert property (s_wdog_only |=> ntc1_q[5:4] == 2'h1)
    else $error("warm threshold not restored on watchdog");
  chk_hot_lim_wdog: assert property (s_wdog_only |=> ntc1_q[3:2] == 2'h1)
    else $error("hot limit not restored on watchdog");
  chk_cold_lim_wdog: assert property (s_wdog_only |=> !ntc1_q[1])
    else $error("cold limit not restored on watchdog");
  chk_override_wdog: assert property (s_wdog_only |=> !ntc1_q[0])
    else $error("override not cleared on watchdog");
  chk_wdog_drops_wr: assert property (i_wdog_expire && !i_reg_reset && wr18 |=>
                                      ntc1_q == `CTN_RST_NTC1)
    else $error("write beat the watchdog");
  chk_ntc1_read: assert property (s_rd_ntc1 |=> rdata == $past(ntc1_q))
    else $error("threshold select read wrong");

  // Status path and unmapped reads
  chk_ts_pass: assert property (!ntc1_q[`CTN_NTC1_IGNORE] |=>
                                ts_stat == $past(i_ts_status_raw) && !ts_forced)
    else $error("thermistor status not passed through");
  chk_unmapped_read: assert property (i_rd_en && (i_addr < `CTN_OFS_CTRL5 ||
                                      i_addr > `CTN_OFS_NTC1) |=> rdata == 8'h00)
    else $error("unmapped read nonzero");

endmodule : ctn_regs

//--- tb_ctn_regs.sv
// Purpose: Self-checking bench for the thermal and thermistor config registers
// Assumes: Single-cycle strobes driven at falling edge, read data one cycle late
// Notes:   Watchdog and register reset are pulsed with a colliding write
`timescale 1ns/1ns
`include "ctn_params.svh"

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_ctn_regs;
  import ctn_pkg::*;

  logic       i_sys_clk = 1'b0;
  logic       i_rst_n = 1'b0;
  logic       i_wr_en = 1'b0;
  logic       i_rd_en = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_reg_reset = 1'b0;
  logic       i_wdog_expire = 1'b0;
  logic [3:0] i_ts_status_raw = 4'h0;
  logic [7:0] o_rdata;
  logic       o_oc_en;
  logic       o_ship;
  ctn_temp_s  o_temp_cfg;
  ctn_ntc0_s  o_ntc0_cfg;
  ctn_ntc1_s  o_ntc1_cfg;
  logic [3:0] o_ts_status;
  logic       o_ts_forced;
  int         fails = 0;
  int         tests_run = 0;
  int         cycles = 0;
  logic [7:0] ofs [6] = '{`CTN_OFS_CTRL5, `CTN_OFS_RSVD, `CTN_OFS_TEMP,
                          `CTN_OFS_NTC0, `CTN_OFS_NTC1, 8'h20};
  logic [7:0] rst_val [6] = '{8'h00, `CTN_RST_RSVD, `CTN_RST_TEMP,
                              `CTN_RST_NTC0, `CTN_RST_NTC1, 8'h00};

  always #10 i_sys_clk = ~i_sys_clk;

  ctn_regs i_ctn_regs (
    .i_sys_clk                      (i_sys_clk),
    .i_rst_n                        (i_rst_n),
    .i_wr_en                        (i_wr_en),
    .i_rd_en                        (i_rd_en),
    .i_addr                         (i_addr),
    .i_wdata                        (i_wdata),
    .i_reg_reset                    (i_reg_reset),
    .i_wdog_expire                  (i_wdog_expire),
    .i_ts_status_raw                (i_ts_status_raw),
    .o_rdata                        (o_rdata),
    .o_discharge_overcurrent_enable (o_oc_en),
    .o_ship_switch_fitted           (o_ship),
    .o_temp_cfg                     (o_temp_cfg),
    .o_ntc0_cfg                     (o_ntc0_cfg),
    .o_ntc1_cfg                     (o_ntc1_cfg),
    .o_ts_status                    (o_ts_status),
    .o_ts_good_forced               (o_ts_forced)
  );

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_wr_en = 1'b1; i_addr = a; i_wdata = d;
    @(negedge i_sys_clk);
    i_wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_sys_clk);
    i_rd_en = 1'b1; i_addr = a;
    @(negedge i_sys_clk);
    i_rd_en = 1'b0;
    @(negedge i_sys_clk);
    `CHK(o_rdata, exp)
  endtask : rd

  // Write collides with the pulse and must be dropped
  task automatic pulse(input logic wdog);
    @(negedge i_sys_clk);
    i_wdog_expire = wdog; i_reg_reset = ~wdog;
    i_wr_en = 1'b1; i_addr = `CTN_OFS_NTC1; i_wdata = 8'h00;
    @(negedge i_sys_clk);
    i_wdog_expire = 1'b0; i_reg_reset = 1'b0; i_wr_en = 1'b0;
  endtask : pulse

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // Generous ceiling; the sequence needs well under 300 cycles
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    for (int k = 0; k < 6; k++) rd(ofs[k], rst_val[k]);
    `CHK(o_temp_cfg.thermal_regulation_select, 2'h3)
    `CHK(o_temp_cfg.thermal_shutdown_select, 2'h0)
    `CHK(o_ntc0_cfg.warm_zone_voltage_select, 3'h3)
    `CHK({o_ntc0_cfg.warm_zone_current_select, o_ntc0_cfg.cool_zone_current_select}, 4'hD)
    `CHK(o_ntc1_cfg, 8'h54)
    wr(`CTN_OFS_CTRL5, 8'h01);
    rd(`CTN_OFS_CTRL5, 8'h00);
    `CHK(o_oc_en, 1'b0)
    `CHK(o_ship, 1'b0)
    wr(`CTN_OFS_CTRL5, 8'h81);
    rd(`CTN_OFS_CTRL5, 8'h81);
    `CHK(o_oc_en, 1'b1)
    `CHK(o_ship, 1'b1)
    for (int k = 1; k < 5; k++) wr(ofs[k], 8'hFF);
    for (int k = 1; k < 5; k++) rd(ofs[k], {7'h7F & {7{k != 1}}, k == 4});
    i_ts_status_raw = 4'hF;
    repeat (2) @(negedge i_sys_clk);
    `CHK({o_ts_forced, o_ts_status}, 5'h10)
    // Watchdog keeps only the pull-down enables and the ship bit
    pulse(1'b1);
    rd(`CTN_OFS_TEMP, 8'hCE);
    rd(`CTN_OFS_NTC0, 8'h7A);
    rd(`CTN_OFS_NTC1, 8'h54);
    rd(`CTN_OFS_CTRL5, 8'h80);
    `CHK({o_ts_forced, o_ts_status}, 5'h0F)
    wr(`CTN_OFS_CTRL5, 8'h81);
    wr(`CTN_OFS_NTC0, 8'h06);
    pulse(1'b0);
    rd(`CTN_OFS_TEMP, 8'hC0);
    rd(`CTN_OFS_NTC0, 8'h7A);
    `CHK(o_oc_en, 1'b0)
    `CHK(o_ship, 1'b1)
    wr(`CTN_OFS_CTRL5, 8'h81);
    wr(`CTN_OFS_CTRL5, 8'h01);
    rd(`CTN_OFS_CTRL5, 8'h00);
    `CHK(o_oc_en, 1'b0)
    end_sim();
  end
endmodule : tb_ctn_regs
